// [shared/serial_bus_pkg.sv]
// constants, field positions and types of the two-wire serial core
// assumes a 32-bit classic wishbone bus with 16-bit registers in low bits
package serial_bus_pkg;

    // register byte offsets on the bus
    localparam logic [7:0] OFF_CONTROL   = 8'h00;
    localparam logic [7:0] OFF_STATUS    = 8'h04;
    localparam logic [7:0] OFF_RECEIVE   = 8'h08;
    localparam logic [7:0] OFF_TRANSMIT  = 8'h0c;
    localparam logic [7:0] OFF_ADDRESS   = 8'h10;
    localparam logic [7:0] OFF_RELOAD    = 8'h14;
    localparam logic [7:0] OFF_EVENT     = 8'h18;
    localparam logic [7:0] OFF_EVENT_EN  = 8'h1c;
    localparam logic [7:0] OFF_EVENT_CLR = 8'h20;

    // control register fields
    localparam int CTL_ENABLE    = 15;
    localparam int CTL_IDLE_HALT = 13;
    localparam int CTL_RELEASE   = 12;
    localparam int CTL_TEN_BIT   = 10;
    localparam int CTL_STRETCH   = 6;
    localparam logic [15:0] CONTROL_RESET = 16'h1000;
    localparam logic [15:0] CONTROL_WMASK = 16'hbfff;

    // status register fields, low six are read-only
    localparam int ST_RX_FULL = 0;
    localparam int ST_TX_FULL = 1;
    localparam int ST_READ    = 2;
    localparam int ST_START   = 3;
    localparam int ST_STOP    = 4;
    localparam int ST_TEN     = 5;
    localparam int ST_RX_OVF  = 6;
    localparam logic [9:0] STATUS_RW_RESET = 10'h000;

    // event bits for the interrupt registers
    localparam int EV_RX   = 0;
    localparam int EV_TX   = 1;
    localparam int EV_STOP = 2;
    localparam int EV_W    = 3;

    // other reset values and codes
    localparam logic [15:0] RELOAD_RESET  = 16'h0000;
    localparam logic [9:0]  ADDRESS_RESET = 10'h000;
    localparam logic [7:0]  BYTE_RESET    = 8'h00;
    localparam logic [4:0]  TEN_HEADER    = 5'h1e;
    localparam logic [2:0]  LAST_BIT      = 3'h7;

    // slave sequencing states
    typedef enum logic [2:0] {
        S_IDLE     = 3'b000,
        S_ADDR     = 3'b001,
        S_ADDR_LO  = 3'b010,
        S_ACK_ADDR = 3'b011,
        S_RX       = 3'b100,
        S_ACK_DATA = 3'b101,
        S_TX       = 3'b110,
        S_TX_ACK   = 3'b111
    } slave_state_t;

    // the two bus lines travel together
    typedef struct packed {
        logic scl;
        logic sda;
    } line_pair_t;

endpackage : serial_bus_pkg

// [src/line_sync.sv]
// two-flop synchroniser for the clock and data lines of the serial bus
// assumes the lines idle high and arrive from outside the clock domain
`timescale 1ns/1ps
module line_sync
    import serial_bus_pkg::*;
(
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // raw and synchronised lines
    input  wire line_pair_t async_i,
    output line_pair_t      sync_o
);

    logic [1:0] raw;   // raw lines as bits
    logic [1:0] meta;  // first stage, read only by second
    logic [1:0] held;  // second stage, safe to use

    assign raw = async_i;

    // one pair of flops per line
    for (genvar i = 0; i < 2; i++) begin : g_line
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                meta[i] <= 1'b1;
                held[i] <= 1'b1;
            end else begin
                meta[i] <= raw[i];
                held[i] <= meta[i];
            end
        end
    end

    assign sync_o = held;

endmodule : line_sync

// [src/serial_bus_core.sv]
// register core and slave sequencer of a two-wire serial peripheral
// assumes classic wishbone on clk_i and an open-drain bus outside
// Functional notes
// - shift register hidden from software
// - full byte moves to buffer, pulses
// - software reads received bytes from buffer
// - software writes bytes to transmit register
// - own slave address held in register
// - status flag shows ten-bit addressing
// - reload register sets bit-rate counter count
// - control register readable, writable except bit 14
// - low six status bits read-only
// - release bit frees clock, zero stretches
// - with stretch enable, software writes release
// - hardware clears release at transmit start
// - hardware clears release after reception
`timescale 1ns/1ps
module serial_bus_core
    import serial_bus_pkg::*;
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic             wb_ack_o,
    output logic [31:0]      wb_dat_o,
    // processor state and interrupt
    input  wire logic        idle_i,
    output logic             irq_o,
    // serial bus pins, open drain
    input  wire logic        serial_clock_pin_i,
    output logic             serial_clock_pin_o,
    output logic             serial_clock_pin_oe_o,
    input  wire logic        serial_data_pin_i,
    output logic             serial_data_pin_o,
    output logic             serial_data_pin_oe_o,
    output logic             pins_enable_o
);

    // bus request decode
    logic        req;          // new access this cycle
    logic        wr;           // new write
    logic        rd;           // new read
    logic [15:0] read_mux;     // selected read value
    logic [15:0] status_merge; // status after a write
    logic [15:0] addr_merge;   // own address after a write

    // software registers
    logic [15:0] serial_bus_control;
    logic [9:0]  status_rw;        // writable status bits 15:6
    logic [7:0]  receive_buffer;
    logic [7:0]  transmit_holding;
    logic [9:0]  own_slave_address;
    logic [15:0] bit_rate_reload;
    logic [EV_W-1:0] ev_status;    // sticky events
    logic [EV_W-1:0] ev_enable;    // event mask
    logic        rx_full;
    logic        tx_full;

    // slave sequencer state
    slave_state_t state;
    logic [7:0]  bit_shift_register;
    logic [2:0]  bit_cnt;
    logic        ack_phase;        // ack bit being driven
    logic        ten_done;         // second address byte received, match or not
    logic        read_dir;         // master reads from us
    logic        start_seen;
    logic        stop_seen;
    logic        rx_pulse;         // byte landed in buffer
    logic        tx_pulse;         // byte loaded for sending
    logic        stop_pulse;       // stop seen while sequencer not in S_IDLE
    logic        rel_clr;          // hardware clear of release

    // line sampling and edges
    line_pair_t  lines_raw;
    line_pair_t  lines;
    line_pair_t  lines_q;
    logic        scl_rise;
    logic        scl_fall;
    logic        start_cond;
    logic        stop_cond;
    logic        active;
    logic [7:0]  next_byte;        // shifter with new bit
    logic        drive_low;        // we want data low
    logic        ten_mode;

    // data output hold timing
    logic [15:0] bit_rate_counter;
    logic        hold_pend;
    logic        hold_done;

    // both lines cross into clk_i before any logic looks at them
    assign lines_raw.scl = serial_clock_pin_i;
    assign lines_raw.sda = serial_data_pin_i;

    line_sync u_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .async_i (lines_raw),
        .sync_o  (lines)
    );

    // previous sample for edge finding
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lines_q <= '1;
        end else begin
            lines_q <= lines;
        end
    end

    assign scl_rise   = lines.scl & ~lines_q.scl;
    assign scl_fall   = ~lines.scl & lines_q.scl;
    assign start_cond = lines.scl & lines_q.scl & lines_q.sda & ~lines.sda;
    assign stop_cond  = lines.scl & lines_q.scl & ~lines_q.sda & lines.sda;
    assign next_byte  = {bit_shift_register[6:0], lines.sda};
    assign ten_mode   = serial_bus_control[CTL_TEN_BIT];

    assign active = serial_bus_control[CTL_ENABLE]
                  & ~(serial_bus_control[CTL_IDLE_HALT] & idle_i);

    // ack bits and transmit data pull the line low
    assign drive_low = ((state == S_ACK_ADDR || state == S_ACK_DATA)
                        && ack_phase)
                     || (state == S_TX && !bit_shift_register[7]);

    // wishbone decode, one access per ack
    assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr  = req & wb_we_i;
    assign rd  = req & ~wb_we_i;

    // merge a write into a 16-bit register by byte lanes
    function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                               input logic [31:0] data,
                                               input logic [3:0]  sel);
        logic [15:0] res;
        res = old;
        if (sel[0]) res[7:0] = data[7:0];
        if (sel[1]) res[15:8] = data[15:8];
        return res;
    endfunction : lane_merge

    // merged values, cut back to register width where they are used
    assign status_merge = lane_merge({status_rw, 6'h00}, wb_dat_i, wb_sel_i);
    assign addr_merge   = lane_merge({6'h00, own_slave_address}, wb_dat_i,
                                     wb_sel_i);

    // read multiplexer; shift register has no address at all
    always_comb begin
        if (wb_adr_i == OFF_CONTROL) begin
            read_mux = serial_bus_control;
        end else if (wb_adr_i == OFF_STATUS) begin
            read_mux = {status_rw, ten_mode & ten_done, stop_seen,
                        start_seen, read_dir, tx_full, rx_full};
        end else if (wb_adr_i == OFF_RECEIVE) begin
            read_mux = {8'h00, receive_buffer};
        end else if (wb_adr_i == OFF_TRANSMIT) begin
            read_mux = {8'h00, transmit_holding};
        end else if (wb_adr_i == OFF_ADDRESS) begin
            read_mux = {6'h00, own_slave_address};
        end else if (wb_adr_i == OFF_RELOAD) begin
            read_mux = bit_rate_reload;
        end else if (wb_adr_i == OFF_EVENT) begin
            read_mux = {13'h0000, ev_status};
        end else if (wb_adr_i == OFF_EVENT_EN) begin
            read_mux = {13'h0000, ev_enable};
        end else begin
            // clear register and holes read zero
            read_mux = 16'h0000;
        end
    end

    // bus answer, one cycle after the request is seen
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= req;
            if (rd) begin
                wb_dat_o <= {16'h0000, read_mux};
            end
        end
    end

    // control register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            serial_bus_control <= CONTROL_RESET;
        end else begin
            if (wr && wb_adr_i == OFF_CONTROL) begin
                serial_bus_control <= lane_merge(serial_bus_control,
                                      wb_dat_i, wb_sel_i) & CONTROL_WMASK;
                // zero only takes when stretching is enabled
                if (!serial_bus_control[CTL_STRETCH] && wb_sel_i[1]
                    && !wb_dat_i[CTL_RELEASE]) begin
                    serial_bus_control[CTL_RELEASE] <=
                        serial_bus_control[CTL_RELEASE];
                end
            end
            // hardware clear beats a same-cycle write
            if (rel_clr) begin
                serial_bus_control[CTL_RELEASE] <= 1'b0;
            end
        end
    end

    // writable upper status bits, overflow set wins over a write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_rw <= STATUS_RW_RESET;
        end else begin
            if (wr && wb_adr_i == OFF_STATUS) begin
                status_rw <= status_merge[15:6];
            end
            if (rx_pulse && rx_full) begin
                status_rw[ST_RX_OVF-6] <= 1'b1;
            end
        end
    end

    // plain configuration and data registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            transmit_holding  <= BYTE_RESET;
            own_slave_address <= ADDRESS_RESET;
            bit_rate_reload   <= RELOAD_RESET;
            ev_enable         <= '0;
        end else begin
            if (wr && wb_adr_i == OFF_TRANSMIT && wb_sel_i[0]) begin
                transmit_holding <= wb_dat_i[7:0];
            end
            if (wr && wb_adr_i == OFF_ADDRESS) begin
                own_slave_address <= addr_merge[9:0];
            end
            if (wr && wb_adr_i == OFF_RELOAD) begin
                bit_rate_reload <= lane_merge(bit_rate_reload, wb_dat_i,
                                              wb_sel_i);
            end
            if (wr && wb_adr_i == OFF_EVENT_EN && wb_sel_i[0]) begin
                ev_enable <= wb_dat_i[EV_W-1:0];
            end
        end
    end

    // buffer flags; receive: hardware set wins over read clear, transmit: write set wins over hardware clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_full <= 1'b0;
            tx_full <= 1'b0;
        end else begin
            if (rd && wb_adr_i == OFF_RECEIVE) begin
                rx_full <= 1'b0;
            end
            if (rx_pulse) begin
                rx_full <= 1'b1;
            end
            if (tx_pulse) begin
                tx_full <= 1'b0;
            end
            if (wr && wb_adr_i == OFF_TRANSMIT && wb_sel_i[0]) begin
                tx_full <= 1'b1;
            end
        end
    end

    // sticky events and interrupt level
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ev_status <= '0;
            irq_o     <= 1'b0;
        end else begin
            if (wr && wb_adr_i == OFF_EVENT_CLR && wb_sel_i[0]) begin
                ev_status <= ev_status & ~wb_dat_i[EV_W-1:0]
                           | {stop_pulse, tx_pulse, rx_pulse};
            end else begin
                ev_status <= ev_status | {stop_pulse, tx_pulse, rx_pulse};
            end
            irq_o <= |(ev_status & ev_enable);
        end
    end

    // slave sequencer, advanced by sampled clock-line edges
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state              <= S_IDLE;
            bit_shift_register <= BYTE_RESET;
            receive_buffer     <= BYTE_RESET;
            bit_cnt            <= 3'h0;
            ack_phase          <= 1'b0;
            ten_done           <= 1'b0;
            read_dir           <= 1'b0;
            start_seen         <= 1'b0;
            stop_seen          <= 1'b0;
            rx_pulse           <= 1'b0;
            tx_pulse           <= 1'b0;
            stop_pulse         <= 1'b0;
            rel_clr            <= 1'b0;
        end else begin
            rx_pulse   <= 1'b0;
            tx_pulse   <= 1'b0;
            stop_pulse <= 1'b0;
            rel_clr    <= 1'b0;
            if (!serial_bus_control[CTL_ENABLE]) begin
                state <= S_IDLE;
            end else if (!active) begin
                // halted in idle: sequencer state and registers hold, pulses clear
                state <= state;
            end else if (start_cond) begin
                state      <= S_ADDR;
                bit_cnt    <= 3'h0;
                ten_done   <= 1'b0;
                start_seen <= 1'b1;
                stop_seen  <= 1'b0;
            end else if (stop_cond) begin
                stop_pulse <= (state != S_IDLE);
                state      <= S_IDLE;
                stop_seen  <= 1'b1;
                start_seen <= 1'b0;
            end else begin
                case (state)
                    S_ADDR, S_ADDR_LO, S_RX: begin
                        if (scl_rise) begin
                            bit_shift_register <= next_byte;
                            bit_cnt            <= bit_cnt + 3'h1;
                            ack_phase          <= 1'b0;
                            if (bit_cnt == LAST_BIT) begin
                                if (state == S_RX) begin
                                    receive_buffer <= next_byte;
                                    rx_pulse       <= 1'b1;
                                    state          <= S_ACK_DATA;
                                    rel_clr <= serial_bus_control[CTL_STRETCH];
                                end else if (state == S_ADDR_LO) begin
                                    ten_done <= 1'b1;
                                    state <= (next_byte ==
                                              own_slave_address[7:0])
                                             ? S_ACK_ADDR : S_IDLE;
                                end else if (ten_mode) begin
                                    read_dir <= next_byte[0];
                                    state <= (next_byte[7:1] == {TEN_HEADER,
                                              own_slave_address[9:8]})
                                             ? S_ACK_ADDR : S_IDLE;
                                end else begin
                                    read_dir <= next_byte[0];
                                    state <= (next_byte[7:1] ==
                                              own_slave_address[6:0])
                                             ? S_ACK_ADDR : S_IDLE;
                                end
                            end
                        end
                    end
                    S_ACK_ADDR, S_ACK_DATA: begin
                        // first fall drives ack, second ends it
                        if (scl_fall && !ack_phase) begin
                            ack_phase <= 1'b1;
                        end else if (scl_fall) begin
                            ack_phase <= 1'b0;
                            bit_cnt   <= 3'h0;
                            if (state == S_ACK_ADDR && ten_mode
                                && !ten_done && !read_dir) begin
                                state <= S_ADDR_LO;
                            end else if (read_dir) begin
                                bit_shift_register <= transmit_holding;
                                tx_pulse <= 1'b1;
                                rel_clr  <= serial_bus_control[CTL_STRETCH];
                                state    <= S_TX;
                            end else begin
                                state <= S_RX;
                            end
                        end
                    end
                    S_TX: begin
                        // bits change after falls, eight in all
                        if (scl_fall) begin
                            if (bit_cnt == LAST_BIT) begin
                                state <= S_TX_ACK;
                            end else begin
                                bit_shift_register <=
                                    {bit_shift_register[6:0], 1'b0};
                                bit_cnt <= bit_cnt + 3'h1;
                            end
                        end
                    end
                    S_TX_ACK: begin
                        // master nack ends the read
                        if (scl_rise && lines.sda) begin
                            state <= S_IDLE;
                        end else if (scl_fall) begin
                            bit_shift_register <= transmit_holding;
                            bit_cnt  <= 3'h0;
                            tx_pulse <= 1'b1;
                            rel_clr  <= serial_bus_control[CTL_STRETCH];
                            state    <= S_TX;
                        end
                    end
                    default: begin
                        state <= S_IDLE;
                    end
                endcase
            end
        end
    end

    // data hold after each clock fall, counted from the reload value
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bit_rate_counter <= RELOAD_RESET;
            hold_pend        <= 1'b0;
        end else if (active && scl_fall) begin
            bit_rate_counter <= bit_rate_reload;
            hold_pend        <= 1'b1;
        end else if (hold_pend && bit_rate_counter != 16'h0000) begin
            bit_rate_counter <= bit_rate_counter - 16'h0001;
        end else begin
            hold_pend <= 1'b0;
        end
    end

    assign hold_done = hold_pend && bit_rate_counter == 16'h0000;

    // pin drivers; open drain so the driven level is always low
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            serial_clock_pin_o    <= 1'b0;
            serial_clock_pin_oe_o <= 1'b0;
            serial_data_pin_o     <= 1'b0;
            serial_data_pin_oe_o  <= 1'b0;
            pins_enable_o         <= 1'b0;
        end else begin
            serial_clock_pin_o <= 1'b0;
            serial_data_pin_o  <= 1'b0;
            pins_enable_o <= serial_bus_control[CTL_ENABLE];
            // clock held while release is zero
            serial_clock_pin_oe_o <= serial_bus_control[CTL_ENABLE]
                                   & ~serial_bus_control[CTL_RELEASE];
            if (!serial_bus_control[CTL_ENABLE]) begin
                serial_data_pin_oe_o <= 1'b0;
            end else if (hold_done) begin
                serial_data_pin_oe_o <= drive_low;
            end
        end
    end

endmodule : serial_bus_core

// [sim/serial_bus_core_asserts.sv]
// port checker for the serial bus core
// bound into every core instance by the bench
`timescale 1ns/1ps
module serial_bus_core_asserts
    import serial_bus_pkg::*;
(
    // mirrors of core ports
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic        wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    input wire logic        serial_clock_pin_oe_o,
    input wire logic        serial_data_pin_oe_o,
    input wire logic        pins_enable_o,
    input wire logic        irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // control write at its ack edge
    wire wr = wb_ack_o && wb_we_i && wb_adr_i == OFF_CONTROL;
    // stretch enable as last written; a zero release needs it already on
    logic str_on;
    always_ff @(posedge clk_i) begin
        if (rst_i) str_on <= 1'b0;
        else if (wr) str_on <= wb_dat_i[6];
    end
    property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    a_ack: assert property (p_ack) else $error("ack late");
    property p_one; wb_ack_o |=> !wb_ack_o; endproperty
    a_one: assert property (p_one) else $error("ack too long");
    property p_hi; wb_ack_o |-> wb_dat_o[31:16] == 16'h0000; endproperty
    a_hi: assert property (p_hi) else $error("upper read bits set");
    property p_map; wb_ack_o && !wb_we_i && wb_adr_i == 8'h24
        |-> wb_dat_o == 32'h0; endproperty
    a_map: assert property (p_map) else $error("unmapped read nonzero");
    property p_en; wr |=> pins_enable_o == $past(wb_dat_i[15]); endproperty
    a_en: assert property (p_en) else $error("pin handover wrong");
    property p_off; !pins_enable_o [*2]
        |=> !serial_clock_pin_oe_o && !serial_data_pin_oe_o; endproperty
    a_off: assert property (p_off) else $error("pins driven off");
    property p_str; wr && str_on && wb_dat_i[15] && wb_dat_i[6]
        && !wb_dat_i[12] |-> ##[1:3] serial_clock_pin_oe_o; endproperty
    a_str: assert property (p_str) else $error("no stretch");
    property p_rel; wr && wb_dat_i[15] && wb_dat_i[12]
        |-> ##[1:3] !serial_clock_pin_oe_o; endproperty
    a_rel: assert property (p_rel) else $error("clock not freed");
    c_wr: cover property (wr);
    c_irq: cover property (irq_o);
    c_str: cover property (serial_clock_pin_oe_o);
endmodule : serial_bus_core_asserts

// [sim/i2c_master_model.sv]
// line master model, 160 ns clock, open drain
// assumes pull-ups; core enables pull lines low
`timescale 1ns/1ps
module i2c_master_model (
    // core pull-down enables
    input  wire logic scl_oe_i,
    input  wire logic sda_oe_i,
    // resolved line levels
    output logic      scl_o,
    output logic      sda_o
);
    logic scl_low = 1'b0;  // model pulls clock
    logic sda_low = 1'b0;  // model pulls data
    // wired-and, released line reads high
    assign scl_o = !(scl_low || scl_oe_i);
    assign sda_o = !(sda_low || sda_oe_i);
    // nine clocks msb first, waits out a stretch
    task automatic put(input logic [7:0] v, output logic ak);
        for (int i = 8; i >= 0; i--) begin
            #40 sda_low = (i > 0) ? !v[i-1] : 1'b0;
            #40 scl_low = 1'b0;
            wait (scl_o);
            #80 ak = sda_o;
            scl_low = 1'b1;
        end
    endtask : put
    // start, two bytes, stop
    task automatic frame(input logic [7:0] a, input logic [7:0] d,
                         output logic aa, output logic ad);
        sda_low = 1'b1;
        #80 scl_low = 1'b1;
        put(a, aa);
        put(d, ad);
        sda_low = 1'b1;
        #40 scl_low = 1'b0;
        #80 sda_low = 1'b0;
    endtask : frame
endmodule : i2c_master_model

// [sim/serial_bus_core_tb.sv]
// self-checking bench for the serial bus core
// drives wishbone; the line model plays the far side
`timescale 1ns/1ps
`define CK(n, e, a) begin compares++; if ((a) !== (e)) begin mismatches++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
bind serial_bus_core serial_bus_core_asserts chk (.*);
module serial_bus_core_tb
    import serial_bus_pkg::*;
;
    logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
    logic idle_i = 0, irq_o, wb_ack_o, pins_enable_o, a1, a2;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h3;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
    logic [15:0] q;
    logic serial_clock_pin_i, serial_clock_pin_o, serial_clock_pin_oe_o;
    logic serial_data_pin_i, serial_data_pin_o, serial_data_pin_oe_o;
    int mismatches = 0, compares = 0;
    initial forever #4 clk_i = ~clk_i;
    serial_bus_core uut (.*);
    i2c_master_model m (.scl_oe_i(serial_clock_pin_oe_o),
        .sda_oe_i(serial_data_pin_oe_o), .scl_o(serial_clock_pin_i),
        .sda_o(serial_data_pin_i));
    // one classic cycle, held until ack
    task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
        wb_cyc_i <= 1'b1; wb_stb_i <= 1'b1; wb_we_i <= w; wb_adr_i <= a;
        wb_dat_i <= {16'h0000, d};
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        q = wb_dat_o[15:0];
        wb_cyc_i <= 1'b0; wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask : bus
    task automatic t_reset();
        bus(0, OFF_CONTROL, 0); `CK("control", CONTROL_RESET, q)
        bus(0, OFF_STATUS, 0); `CK("status", 16'h0000, q)
    endtask : t_reset
    task automatic t_regs();
        bus(1, OFF_CONTROL, 16'hffff); bus(0, OFF_CONTROL, 0);
        `CK("control rw", CONTROL_WMASK, q)
        bus(1, OFF_STATUS, 16'hffff); bus(0, OFF_STATUS, 0);
        `CK("status rw", 16'hffc0, q)
        bus(1, OFF_RELOAD, 16'h0003); bus(0, OFF_RELOAD, 0);
        `CK("reload", 16'h0003, q)
        bus(1, OFF_ADDRESS, 16'hffff); bus(0, OFF_ADDRESS, 0);
        `CK("address", 16'h03ff, q)
        bus(1, OFF_ADDRESS, 16'h0052); bus(1, OFF_STATUS, 0);
        bus(0, 8'h24, 0); bus(1, OFF_CONTROL, 16'h1000);
    endtask : t_regs
    task automatic t_rx();
        bus(1, OFF_CONTROL, 16'h9040);
        bus(1, OFF_CONTROL, 16'h8040); `CK("stretch", 1'b1, serial_clock_pin_oe_o)
        bus(1, OFF_CONTROL, 16'h9040); `CK("free", 1'b0, serial_clock_pin_oe_o)
        bus(1, OFF_EVENT_EN, 16'h0001);
        fork
            m.frame(8'ha4, 8'ha5, a1, a2);
            begin
                repeat (20000) if (irq_o !== 1'b1) @(posedge clk_i);
                `CK("rx irq", 1'b1, irq_o)
                bus(0, OFF_RECEIVE, 0); `CK("rx byte", 16'h00a5, q)
                bus(0, OFF_CONTROL, 0); `CK("hw clear", 1'b0, q[CTL_RELEASE])
                `CK("held", 1'b1, serial_clock_pin_oe_o)
                bus(1, OFF_EVENT_EN, 0); `CK("masked", 1'b0, irq_o)
                bus(1, OFF_EVENT_EN, 1); `CK("unmasked", 1'b1, irq_o)
                bus(1, OFF_EVENT_CLR, 1); `CK("cleared", 1'b0, irq_o)
                bus(1, OFF_CONTROL, 16'h9040);
            end
        join
        `CK("addr ack", 1'b0, a1)
        `CK("data ack", 1'b0, a2)
    endtask : t_rx
    task automatic close_out();
        if (mismatches == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : close_out
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_regs();
        t_rx();
        close_out();
    end
    initial begin
        repeat (60000) @(posedge clk_i);
        mismatches++;
        close_out();
    end
endmodule : serial_bus_core_tb
